//--- inc/pcie_port_caps_map.svh
// Purpose: Offsets, field positions, reset values for the port status and link capability block.
// Assumes: Configuration space is addressed by byte offset with dword-aligned accesses.
// Notes: Included by its bare name; definitions only.
`ifndef PCIE_PORT_CAPS_MAP_SVH
`define PCIE_PORT_CAPS_MAP_SVH

// Register byte offsets in configuration space.
`define PPC_OFS_DEV_ERR_STATUS   12'h0_0c8
`define PPC_OFS_LINK_CAP_INFO    12'h0_0cc

// Device status fields, positions within the dword at the status offset.
`define PPC_BIT_ERR_CORR         16
`define PPC_BIT_ERR_NONFATAL     17
`define PPC_BIT_ERR_FATAL        18
`define PPC_BIT_ERR_UNSUP        19
`define PPC_BIT_AUX_PWR          20
`define PPC_BIT_TXN_PEND         21
`define PPC_ERR_LSB              16
`define PPC_BE_ERR_LANE          2

// Link capability field positions.
`define PPC_CAP_SPEED_LSB        0
`define PPC_CAP_WIDTH_LSB        4
`define PPC_CAP_ASPM_LSB         10
`define PPC_CAP_L0S_LSB          12
`define PPC_CAP_L1_LSB           15
`define PPC_CAP_CLKPM_BIT        18
`define PPC_CAP_SDOWN_BIT        19
`define PPC_CAP_DLLA_BIT         20
`define PPC_CAP_BWN_BIT          21
`define PPC_CAP_PORT_LSB         24

// Link capability reset values.
`define PPC_RST_SPEED            4'h2
`define PPC_SPEED_2G5            4'h1
`define PPC_RST_WIDTH_X1         6'h01
`define PPC_RST_WIDTH_X2         6'h02
`define PPC_RST_ASPM             2'h3
`define PPC_RST_L0S_LAT          3'h3
`define PPC_RST_L1_LAT           3'h5
`define PPC_RST_CLKPM_UP         1'b1
`define PPC_RST_SDOWN            1'b0
`define PPC_RST_BWN              1'b0
`define PPC_RST_AUX_PWR          1'b1

// Fields that a start-up loader may replace; clock PM is further masked on downstream ports.
`define PPC_OVR_MASK             32'hff2f_fc00
`define PPC_CLKPM_MASK           32'h0004_0000

`endif

//--- inc/pcie_port_caps_pkg.sv
// Purpose: Types shared by the port status and link capability block.
// Assumes: Constants live in pcie_port_caps_map.svh.
// Notes: Holds the state record of the block.
package pcie_port_caps_pkg;

	// Whole state of the register block, registered as one word.
	typedef struct packed {
		logic        upstream;
		logic [3:0]  err;
		logic [31:0] caps;
		logic        locked;
		logic [31:0] rdata;
		logic        rvalid;
	} caps_state_t;

endpackage

//--- core/pcie_port_caps.sv
// Purpose: Device error status half-word and link capability dword of one switch port.
// Assumes: Configuration accesses and error events are synchronous to i_mclk.
// Notes: The device control half at the status offset is owned elsewhere and reads as zero here.
// Straps are taken on every edge in reset, so they must be steady at its last edge.
// The loader window shuts at the first init-done; a late image is dropped without notice.
// How it works
// - Correctable error sets bit 16, write-1 clears.
// - Non-fatal error sets bit 17, write-1 clears.
// - Fatal error sets bit 18, write-1 clears.
// - Unsupported request sets bit 19, write-1 clears.
// - Flags log regardless of reporting enables.
// - Bit 20 shows aux power, read live from i_aux_pwr_det.
// - Transactions pending bit always reads zero.
// - Max speed bits 3:0, reset 5.0 Gb/s.
// - Max width x1, or x2 upstream two-lane.
// - ASPM support reports L0s and L1.
// - L0s exit latency 256 to 512 ns.
// - L1 exit latency 16 to 32 us.
// - Clock PM one upstream, zero downstream.
// - Link active reporting one downstream, zero upstream.
// - Bandwidth notify capability defaults to zero.
// - Port number defaults to port index.
// - Loader may override capability defaults at start-up.
`timescale 1ns/1ps
`default_nettype none
`include "pcie_port_caps_map.svh"

module pcie_port_caps (
	input  wire logic        i_mclk,
	input  wire logic        i_srst,
	// Straps, caught while reset is held.
	input  wire logic        i_upstream,
	input  wire logic        i_two_lane,
	input  wire logic [2:0]  i_port_index,
	// Error detection events, one-cycle pulses.
	input  wire logic        i_err_corr,
	input  wire logic        i_err_nonfatal,
	input  wire logic        i_err_fatal,
	input  wire logic        i_err_unsup,
	// Reporting enables of the device control register.
	input  wire logic [3:0]  i_report_en,
	input  wire logic        i_aux_pwr_det,
	// Start-up override port from the serial host or EEPROM loader.
	input  wire logic        i_ovr_wr,
	input  wire logic [31:0] i_ovr_data,
	input  wire logic        i_init_done,
	output logic             o_ovr_ready,
	// Configuration space access port.
	input  wire logic [11:0] i_cfg_addr,
	input  wire logic        i_cfg_rd,
	input  wire logic        i_cfg_wr,
	input  wire logic [3:0]  i_cfg_be,
	input  wire logic [31:0] i_cfg_wdata,
	output logic [31:0]      o_cfg_rdata,
	output logic             o_cfg_rvalid,
	// Logged error flags for the message logic.
	output logic [3:0]       o_err_flags,
	output logic [3:0]       o_err_report
);

	pcie_port_caps_pkg::caps_state_t s_q;
	pcie_port_caps_pkg::caps_state_t s_d;

	logic [3:0]  err_evt;
	logic [3:0]  err_clr;
	logic [31:0] caps_dflt;
	logic [31:0] ovr_mask;

	// Builds the capability dword a port of the given role starts with.
	function automatic logic [31:0] caps_default(input logic up, input logic two,
			input logic [2:0] idx);
		logic [31:0] c;
		c = 32'h0000_0000;
		c[`PPC_CAP_SPEED_LSB +: 4] = `PPC_RST_SPEED;
		c[`PPC_CAP_WIDTH_LSB +: 6] = (up && two) ? `PPC_RST_WIDTH_X2 : `PPC_RST_WIDTH_X1;
		c[`PPC_CAP_ASPM_LSB +: 2] = `PPC_RST_ASPM;
		c[`PPC_CAP_L0S_LSB +: 3] = `PPC_RST_L0S_LAT;
		c[`PPC_CAP_L1_LSB +: 3] = `PPC_RST_L1_LAT;
		c[`PPC_CAP_CLKPM_BIT] = up ? `PPC_RST_CLKPM_UP : 1'b0;
		c[`PPC_CAP_SDOWN_BIT] = `PPC_RST_SDOWN;
		c[`PPC_CAP_DLLA_BIT] = ~up;
		c[`PPC_CAP_BWN_BIT] = `PPC_RST_BWN;
		c[`PPC_CAP_PORT_LSB +: 8] = {5'h00, idx};
		return c;
	endfunction

	// Address match used by both the write and the read path.
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		return a[11:2] == ofs[11:2];
	endfunction

	// Event and clear vectors in flag order; a clear needs a one in the bit and its byte lane.
	assign err_evt = {i_err_unsup, i_err_fatal, i_err_nonfatal, i_err_corr};
	assign err_clr = (i_cfg_wr && hit(i_cfg_addr, `PPC_OFS_DEV_ERR_STATUS)
		&& i_cfg_be[`PPC_BE_ERR_LANE]) ? i_cfg_wdata[`PPC_ERR_LSB +: 4] : 4'h0;
	assign caps_dflt = caps_default(i_upstream, i_two_lane, i_port_index);
	// Clock PM is fixed at zero on downstream ports, so the loader cannot reach it there.
	assign ovr_mask = s_q.upstream ? `PPC_OVR_MASK : (`PPC_OVR_MASK & ~`PPC_CLKPM_MASK);

	// Next-state logic for the whole block.
	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		if (i_srst) begin
			// Straps are sampled here, by a clocked path, not by an asynchronous load.
			s_d.upstream = i_upstream;
			s_d.err = 4'h0;
			s_d.caps = caps_dflt;
			s_d.locked = 1'b0;
			s_d.rdata = 32'h0000_0000;
		end else begin
			// Set wins over clear so an event in the clearing cycle is kept.
			s_d.err = (s_q.err & ~err_clr) | err_evt;
			if (i_ovr_wr && !s_q.locked) begin
				s_d.caps = (s_q.caps & ~ovr_mask) | (i_ovr_data & ovr_mask);
			end
			if (i_init_done) begin
				s_d.locked = 1'b1;
			end
			if (i_cfg_rd) begin
				s_d.rvalid = 1'b1;
				s_d.rdata = 32'h0000_0000;
				if (hit(i_cfg_addr, `PPC_OFS_DEV_ERR_STATUS)) begin
					s_d.rdata[`PPC_ERR_LSB +: 4] = s_q.err;
					s_d.rdata[`PPC_BIT_AUX_PWR] = i_aux_pwr_det;
					s_d.rdata[`PPC_BIT_TXN_PEND] = 1'b0;
				end else if (hit(i_cfg_addr, `PPC_OFS_LINK_CAP_INFO)) begin
					s_d.rdata = s_q.caps;
				end
			end
		end
	end

	// State register.
	always_ff @(posedge i_mclk) begin
		s_q <= s_d;
	end

	// Read and flag outputs come straight from the state; the report gating and the handshake ready are combinational.
	assign o_cfg_rdata = s_q.rdata;
	assign o_cfg_rvalid = s_q.rvalid;
	assign o_err_flags = s_q.err;
	// Enables only gate what is reported, never what is logged.
	assign o_err_report = s_q.err & i_report_en;
	assign o_ovr_ready = ~s_q.locked & ~i_srst;

	// Checks on the registered behaviour.
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	// The non-fatal, fatal and unsupported checks name their own clear condition, so a write to another lane or
	// another offset never excuses a lost flag.

	property p_corr_set;
		i_err_corr |=> s_q.err[0];
	endproperty
	a_corr_set: assert property (p_corr_set) else $error("correctable flag not set");

	property p_nonfatal_hold;
		s_q.err[1] && !(i_cfg_wr && i_cfg_be[2] && i_cfg_wdata[17]
			&& hit(i_cfg_addr, `PPC_OFS_DEV_ERR_STATUS)) |=> s_q.err[1];
	endproperty
	a_nonfatal_hold: assert property (p_nonfatal_hold) else $error("non-fatal flag lost");

	property p_fatal_clear;
		s_q.err[2] && !i_err_fatal && i_cfg_wr && i_cfg_be[2] && i_cfg_wdata[18]
			&& hit(i_cfg_addr, `PPC_OFS_DEV_ERR_STATUS) |=> !s_q.err[2];
	endproperty
	a_fatal_clear: assert property (p_fatal_clear) else $error("fatal flag not cleared");

	// An event in the clearing cycle must survive the clear.
	property p_unsup_set_wins;
		i_err_unsup && i_cfg_wr && i_cfg_be[`PPC_BE_ERR_LANE] && i_cfg_wdata[`PPC_BIT_ERR_UNSUP]
			&& hit(i_cfg_addr, `PPC_OFS_DEV_ERR_STATUS) |=> o_err_flags[3];
	endproperty
	a_unsup_set_wins: assert property (p_unsup_set_wins) else $error("unsupported flag lost");

	// Logging ignores the enable; reporting follows whatever enable stands now.
	property p_log_no_enable;
		i_err_corr && i_report_en == 4'h0 |=> o_err_flags[0] && (o_err_report[0] == i_report_en[0]);
	endproperty
	a_log_no_enable: assert property (p_log_no_enable) else $error("flag not logged");

	property p_status_read;
		i_cfg_rd && hit(i_cfg_addr, `PPC_OFS_DEV_ERR_STATUS) |=> o_cfg_rvalid
			&& o_cfg_rdata[21] == 1'b0 && o_cfg_rdata[15:0] == 16'h0000
			&& o_cfg_rdata[31:22] == 10'h000 && o_cfg_rdata[20] == $past(i_aux_pwr_det);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	// Only the capability word may carry bit 21, as its bandwidth-notify field.
	property p_pend_zero;
		o_cfg_rvalid |-> !o_cfg_rdata[`PPC_BIT_TXN_PEND]
			|| hit($past(i_cfg_addr), `PPC_OFS_LINK_CAP_INFO);
	endproperty
	a_pend_zero: assert property (p_pend_zero) else $error("pending bit set");

	property p_caps_fixed;
		s_q.caps[3:0] == `PPC_RST_SPEED && s_q.caps[`PPC_CAP_DLLA_BIT] == ~s_q.upstream
			&& s_q.caps[23:22] == 2'b00;
	endproperty
	a_caps_fixed: assert property (p_caps_fixed) else $error("fixed caps field changed");

	property p_width;
		s_q.caps[9:4] == `PPC_RST_WIDTH_X1 || s_q.caps[9:4] == `PPC_RST_WIDTH_X2;
	endproperty
	a_width: assert property (p_width) else $error("width out of range");

	property p_clkpm_down;
		!s_q.upstream |-> !s_q.caps[`PPC_CAP_CLKPM_BIT];
	endproperty
	a_clkpm_down: assert property (p_clkpm_down) else $error("clock PM on downstream");

	property p_ovr_locked;
		s_q.locked |=> $stable(s_q.caps);
	endproperty
	a_ovr_locked: assert property (p_ovr_locked) else $error("caps moved after lock");

	property p_zero_write;
		i_cfg_wr && i_cfg_wdata[19:16] == 4'h0 |=> (s_q.err & $past(s_q.err)) == $past(s_q.err);
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write cleared flag");

	// Holes in the map answer with zero data, never with stale read data.
	property p_unmapped;
		i_cfg_rd && !hit(i_cfg_addr, `PPC_OFS_DEV_ERR_STATUS)
			&& !hit(i_cfg_addr, `PPC_OFS_LINK_CAP_INFO)
			|=> o_cfg_rvalid && o_cfg_rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	// Straps land in the capability word at the last edge in reset.
	property p_dflt_width;
		$fell(i_srst) |-> s_q.caps[`PPC_CAP_WIDTH_LSB +: 6] == (($past(i_upstream)
			&& $past(i_two_lane)) ? `PPC_RST_WIDTH_X2 : `PPC_RST_WIDTH_X1);
	endproperty
	a_dflt_width: assert property (p_dflt_width) else $error("default width wrong");

	// Both power states are advertised out of reset.
	// The loader may narrow this later, so only the reset value is pinned here.
	property p_dflt_aspm;
		$fell(i_srst) |-> s_q.caps[`PPC_CAP_ASPM_LSB +: 2] == `PPC_RST_ASPM;
	endproperty
	a_dflt_aspm: assert property (p_dflt_aspm) else $error("default ASPM support wrong");

	// Short exit latency code out of reset.
	property p_dflt_l0s;
		$fell(i_srst) |-> s_q.caps[`PPC_CAP_L0S_LSB +: 3] == `PPC_RST_L0S_LAT;
	endproperty
	a_dflt_l0s: assert property (p_dflt_l0s) else $error("default L0s latency wrong");

	// Long exit latency code out of reset.
	// A wrong code here makes software budget the wrong wake-up time.
	property p_dflt_l1;
		$fell(i_srst) |-> s_q.caps[`PPC_CAP_L1_LSB +: 3] == `PPC_RST_L1_LAT;
	endproperty
	a_dflt_l1: assert property (p_dflt_l1) else $error("default L1 latency wrong");

	// Clock removal tolerance follows the port role taken in reset.
	property p_dflt_clkpm;
		$fell(i_srst) |-> s_q.caps[`PPC_CAP_CLKPM_BIT] == $past(i_upstream);
	endproperty
	a_dflt_clkpm: assert property (p_dflt_clkpm) else $error("default clock PM wrong");

	// Link active reporting is the inverse of the port role taken in reset.
	property p_dlla_role;
		$fell(i_srst) |-> s_q.caps[`PPC_CAP_DLLA_BIT] == !$past(i_upstream);
	endproperty
	a_dlla_role: assert property (p_dlla_role) else $error("link active capability wrong");

	// Bandwidth notification starts off on every port.
	property p_dflt_bwn;
		$fell(i_srst) |-> s_q.caps[`PPC_CAP_BWN_BIT] == `PPC_RST_BWN;
	endproperty
	a_dflt_bwn: assert property (p_dflt_bwn) else $error("default bandwidth notify wrong");

	// Port number comes from the index strap.
	property p_dflt_port;
		$fell(i_srst) |-> s_q.caps[`PPC_CAP_PORT_LSB +: 8] == {5'h00, $past(i_port_index)};
	endproperty
	a_dflt_port: assert property (p_dflt_port) else $error("default port number wrong");

	// Once locked the loader must see the window shut.
	// A loader that ignored ready would otherwise believe a dropped image landed.
	property p_ovr_closed;
		s_q.locked |-> !o_ovr_ready;
	endproperty
	a_ovr_closed: assert property (p_ovr_closed) else $error("override window still open");

	// Leaving reset shows clear flags and no read in flight.
	// Stale read data across a reset would look like a valid answer to the next master.
	property p_err_reset;
		$fell(i_srst) |-> s_q.err == 4'h0 && !o_cfg_rvalid
			&& o_cfg_rdata == 32'h0000_0000;
	endproperty
	a_err_reset: assert property (p_err_reset) else $error("state not cleared by reset");

	// Main scenarios worth seeing in simulation.
	c_clear_flag: cover property (s_q.err[0] ##1 !s_q.err[0]);
	c_set_and_clear: cover property (i_err_fatal && i_cfg_wr && i_cfg_wdata[18]);
	c_override: cover property (i_ovr_wr && !s_q.locked);
	c_caps_read: cover property (i_cfg_rd && hit(i_cfg_addr, `PPC_OFS_LINK_CAP_INFO) ##1 o_cfg_rvalid);
	c_unsup_kept: cover property (i_err_unsup && i_cfg_wr ##1 o_err_flags[3]);

endmodule // pcie_port_caps

`default_nettype wire

//--- core/pcie_port_caps_unused.sv
`timescale 1ns/1ps

//--- testbench/tb_pcie_port_caps.sv
// Purpose: Self-checking bench for the port error status and link capability block.
// Assumes: Straps are taken in reset; reads answer one cycle after the request edge.
// Notes: Expected words are built from the map constants, never from design outputs.
`timescale 1ns/1ps
`default_nettype none
`include "pcie_port_caps_map.svh"

module tb_pcie_port_caps;
	logic        i_mclk = 1'b0;
	logic        i_srst = 1'b1;
	logic        i_upstream = 1'b0;
	logic        i_two_lane = 1'b0;
	logic [2:0]  i_port_index = 3'h3;
	logic [3:0]  err = 4'h0;
	logic [3:0]  i_report_en = 4'h0;
	logic        i_aux_pwr_det = 1'b1;
	logic        i_ovr_wr = 1'b0;
	logic [31:0] i_ovr_data = 32'h0000_0000;
	logic        i_init_done = 1'b0;
	logic [11:0] i_cfg_addr = 12'h000;
	logic        i_cfg_rd = 1'b0;
	logic        i_cfg_wr = 1'b0;
	logic [3:0]  i_cfg_be = 4'h0;
	logic [31:0] i_cfg_wdata = 32'h0000_0000;
	logic        o_ovr_ready;
	logic [31:0] o_cfg_rdata;
	logic        o_cfg_rvalid;
	logic [3:0]  o_err_flags;
	logic [3:0]  o_err_report;
	int          err_count = 0;
	int          compares = 0;
	logic [31:0] def;

	pcie_port_caps u_pcie_port_caps (.i_mclk(i_mclk), .i_srst(i_srst), .i_upstream(i_upstream),
		.i_two_lane(i_two_lane), .i_port_index(i_port_index), .i_err_corr(err[0]),
		.i_err_nonfatal(err[1]), .i_err_fatal(err[2]), .i_err_unsup(err[3]),
		.i_report_en(i_report_en), .i_aux_pwr_det(i_aux_pwr_det), .i_ovr_wr(i_ovr_wr),
		.i_ovr_data(i_ovr_data), .i_init_done(i_init_done), .o_ovr_ready(o_ovr_ready),
		.i_cfg_addr(i_cfg_addr), .i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr), .i_cfg_be(i_cfg_be),
		.i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
		.o_err_flags(o_err_flags), .o_err_report(o_err_report));

	// Free-running 50 MHz clock.
	always #10 i_mclk = ~i_mclk;

	// Default capability word for a given strap set.
	function automatic logic [31:0] caps_exp(input logic up, input logic two, input logic [7:0] pn);
		caps_exp = {pn, 2'b00, `PPC_RST_BWN, ~up, `PPC_RST_SDOWN, up & `PPC_RST_CLKPM_UP,
			`PPC_RST_L1_LAT, `PPC_RST_L0S_LAT, `PPC_RST_ASPM,
			(up & two) ? `PPC_RST_WIDTH_X2 : `PPC_RST_WIDTH_X1, `PPC_RST_SPEED};
	endfunction

	// Compares a value and counts it; four-state equality so unknowns fail.
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Prints the counts and the verdict, then stops the run.
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Holds reset for 12 cycles with the given straps.
	task automatic do_reset(input logic up, input logic two, input logic [2:0] pi);
		@(posedge i_mclk);
		i_srst <= 1'b1;
		i_upstream <= up;
		i_two_lane <= two;
		i_port_index <= pi;
		i_init_done <= 1'b0;
		repeat (12) @(posedge i_mclk);
		i_srst <= 1'b0;
		@(posedge i_mclk);
		#1;
		check("ovr_ready", 32'h1, {31'h0, o_ovr_ready});
	endtask

	// One configuration read; the answer stands one cycle after the request edge.
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		@(posedge i_mclk);
		i_cfg_addr <= a;
		i_cfg_rd <= 1'b1;
		@(posedge i_mclk);
		i_cfg_rd <= 1'b0;
		#1;
		check("rvalid", 32'h1, {31'h0, o_cfg_rvalid});
		check(nm, exp, o_cfg_rdata);
	endtask

	// One configuration write; its effect shows the cycle after.
	task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge i_mclk);
		i_cfg_addr <= a;
		i_cfg_be <= be;
		i_cfg_wdata <= d;
		i_cfg_wr <= 1'b1;
		@(posedge i_mclk);
		i_cfg_wr <= 1'b0;
		#1;
	endtask

	// Loader write of a full capability image.
	task automatic ovr(input logic [31:0] d);
		@(posedge i_mclk);
		i_ovr_data <= d;
		i_ovr_wr <= 1'b1;
		@(posedge i_mclk);
		i_ovr_wr <= 1'b0;
		#1;
	endtask

	// Main sequence of tests.
	initial begin
		do_reset(1'b0, 1'b0, 3'h3);
		rd(`PPC_OFS_LINK_CAP_INFO, caps_exp(1'b0, 1'b0, 8'h03), "caps_down");
		rd(`PPC_OFS_DEV_ERR_STATUS, 32'h0010_0000, "status_rst");
		$display("Test reset defaults done");
		for (int i = 0; i < 4; i++) begin
			@(posedge i_mclk);
			err[i] <= 1'b1;
			@(posedge i_mclk);
			err[i] <= 1'b0;
			#1;
			check("err_flags", 32'((4'h1 << (i + 1)) - 4'h1), {28'h0, o_err_flags});
		end
		check("err_report_off", 32'h0, {28'h0, o_err_report});
		@(posedge i_mclk);
		i_report_en <= 4'h5;
		#1;
		check("err_report_on", 32'h5, {28'h0, o_err_report});
		wr(`PPC_OFS_DEV_ERR_STATUS, 4'b0100, 32'h0000_0000);
		wr(`PPC_OFS_DEV_ERR_STATUS, 4'b1011, 32'hffff_ffff);
		rd(`PPC_OFS_DEV_ERR_STATUS, 32'h001f_0000, "status_kept");
		wr(`PPC_OFS_DEV_ERR_STATUS, 4'b0100, 32'h0002_0000);
		check("clear_one", 32'hd, {28'h0, o_err_flags});
		wr(`PPC_OFS_DEV_ERR_STATUS, 4'b1111, 32'hffff_ffff);
		@(posedge i_mclk);
		i_aux_pwr_det <= 1'b0;
		rd(`PPC_OFS_DEV_ERR_STATUS, 32'h0000_0000, "status_clr");
		$display("Test error flags done");
		rd(12'h0d4, 32'h0000_0000, "unmapped");
		wr(`PPC_OFS_LINK_CAP_INFO, 4'hf, 32'hffff_ffff);
		def = caps_exp(1'b0, 1'b0, 8'h03);
		rd(`PPC_OFS_LINK_CAP_INFO, def, "caps_ro");
		ovr(32'hffff_ffff);
		def = def | (`PPC_OVR_MASK & ~`PPC_CLKPM_MASK);
		rd(`PPC_OFS_LINK_CAP_INFO, def, "caps_ovr_down");
		@(posedge i_mclk);
		i_init_done <= 1'b1;
		ovr(32'h0000_0000);
		rd(`PPC_OFS_LINK_CAP_INFO, def, "caps_locked");
		check("ovr_closed", 32'h0, {31'h0, o_ovr_ready});
		$display("Test override down done");
		do_reset(1'b1, 1'b1, 3'h5);
		def = caps_exp(1'b1, 1'b1, 8'h05);
		rd(`PPC_OFS_LINK_CAP_INFO, def, "caps_up");
		// Events and a write-1 clear of the same bits in one cycle: the events must win.
		@(posedge i_mclk);
		err <= 4'hc;
		i_cfg_addr <= `PPC_OFS_DEV_ERR_STATUS;
		i_cfg_be <= 4'b0100;
		i_cfg_wdata <= 32'h000c_0000;
		i_cfg_wr <= 1'b1;
		@(posedge i_mclk);
		err <= 4'h0;
		i_cfg_wr <= 1'b0;
		#1;
		check("set_wins", 32'hc, {28'h0, o_err_flags});
		wr(`PPC_OFS_DEV_ERR_STATUS, 4'b0100, 32'h000c_0000);
		check("clear_after", 32'h0, {28'h0, o_err_flags});
		ovr(32'h0000_0000);
		rd(`PPC_OFS_LINK_CAP_INFO, def & ~`PPC_OVR_MASK, "caps_ovr_up");
		$display("Test upstream done");
		report_and_stop();
	end

	// Watchdog: the tests need about 80 cycles.
	initial begin
		repeat (20000) @(posedge i_mclk);
		err_count++;
		report_and_stop();
	end
endmodule // tb_pcie_port_caps

`default_nettype wire
